// >>> inc/dcscr_pkg.sv
// Purpose: constants and types for the dual channel sample capture ram
// Assumes: apb slave, 32-bit data, byte addresses on word boundaries
// Notes: offsets, fields, reset values and state codes
// Function
// - two-channel: ch1 pair 1, ch2 pair 2
// - single ch1: fill pair 2, then pair 1
// - single ch2: pair 2 only, pair 1 idle
// - latch 1 ch1; latch 2 ch2 or active
// - internal address generator feeds address latch
// - bidirectional ch1 buffers; diagnostics drive ch1 input lines
// - two counters sequence settle, pre, post, block
// - capacity 512 kilobytes, 8.192 megabytes expanded
package dcscr_pkg;
    localparam int unsigned SAMPLE_W    = 16;
    localparam int unsigned BANKS       = 4;
    localparam int unsigned SAMPLE_BYTES = 2;
    localparam int unsigned BASE_BYTES  = 512 * 1024;
    localparam int unsigned EXP_BYTES   = 8192 * 1024;
    localparam int unsigned BASE_DEPTH  = BASE_BYTES / (BANKS * SAMPLE_BYTES);
    localparam int unsigned EXP_DEPTH   = EXP_BYTES / (BANKS * SAMPLE_BYTES);
    localparam int unsigned CNT_W       = 24;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SETTLE = 8'h04;
    localparam logic [7:0] OFS_PRE    = 8'h08;
    localparam logic [7:0] OFS_POST   = 8'h0c;
    localparam logic [7:0] OFS_BLOCK  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ADDR   = 8'h18;
    localparam logic [7:0] OFS_DIAG   = 8'h1c;
    localparam logic [7:0] OFS_LIVE   = 8'h20;
    localparam logic [7:0] OFS_RDSEL  = 8'h24;
    localparam logic [7:0] OFS_RDDATA = 8'h28;

    // ctrl fields
    localparam int unsigned CTRL_TWO_CH = 0;
    localparam int unsigned CTRL_CH_SEL = 1;
    localparam int unsigned CTRL_DIAG   = 2;
    localparam int unsigned CTRL_START  = 3;
    // status fields
    localparam int unsigned STAT_DONE   = 0;
    localparam int unsigned STAT_BUSY   = 1;
    localparam int unsigned STAT_ST_LSB = 4;
    // rdsel: bank index in the top two bits
    localparam int unsigned RDSEL_BANK_LSB = 30;

    localparam logic [CNT_W-1:0] SETTLE_RST = 24'h000010;
    localparam logic [CNT_W-1:0] PRE_RST    = 24'h000000;
    localparam logic [CNT_W-1:0] POST_RST   = 24'h000000;
    localparam logic [CNT_W-1:0] BLOCK_RST  = 24'h000400;

    typedef enum logic [2:0] {
        DCSCR_IDLE   = 3'b000,
        DCSCR_SETTLE = 3'b001,
        DCSCR_PRE    = 3'b010,
        DCSCR_ARMED  = 3'b011,
        DCSCR_POST   = 3'b100,
        DCSCR_BLOCK  = 3'b101,
        DCSCR_DONE   = 3'b110
    } dcscr_state_t;
endpackage

// >>> hw/dcscr_trig_cnt.sv
// Purpose: loadable down counter used as a trigger counter
// Assumes: load has priority over counting
// Notes: expired is high while the count stands at zero
`timescale 1ns/1ps
module dcscr_trig_cnt
    import dcscr_pkg::*;
#(
    parameter int unsigned W = CNT_W
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    // status
    output logic              expired
);
    logic [W-1:0] count;
    wire          at_zero = (count == '0);

    assign expired = at_zero;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= '0;
        else if (load)
            count <= load_val;
        else if (dec && !at_zero)
            count <= count - W'(1);
    end
endmodule

// >>> hw/dcscr_top.sv
// Purpose: capture ram for two complex channels with apb control
// Assumes: sample inputs synchronous to pclk; one sample per valid cycle
// Notes: ram banks live here as arrays; capacity set by expanded
`timescale 1ns/1ps
module dcscr_top
    import dcscr_pkg::*;
#(
    parameter bit          EXPANDED = 1'b0,
    parameter int unsigned W        = SAMPLE_W
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // channel 1 input lines, two-way for diagnostics
    input  wire logic [W-1:0] ch1_re_i,
    output logic [W-1:0]      ch1_re_o,
    output logic              ch1_re_oe_n,
    input  wire logic [W-1:0] ch1_im_i,
    output logic [W-1:0]      ch1_im_o,
    output logic              ch1_im_oe_n,
    // channel 2 input lines
    input  wire logic [W-1:0] ch2_re,
    input  wire logic [W-1:0] ch2_im,
    // filter valid and trigger
    input  wire logic         sample_valid,
    input  wire logic         trigger
);
    // bank depth covers the documented capacity
    localparam int unsigned DEPTH = EXPANDED ? EXP_DEPTH : BASE_DEPTH;
    localparam int unsigned AW    = $clog2(DEPTH);
    localparam logic [AW-1:0] ADDR_LAST = AW'(DEPTH - 1);

    dcscr_state_t state;
    dcscr_state_t next_state;

    logic [3:0]       ctrl;
    logic [CNT_W-1:0] settle_len;
    logic [CNT_W-1:0] pre_len;
    logic [CNT_W-1:0] post_len;
    logic [CNT_W-1:0] block_len;
    logic             done;
    logic [31:0]      diag_word;
    logic [31:0]      rdsel;
    logic [W-1:0]     lat1_re;
    logic [W-1:0]     lat1_im;
    logic [W-1:0]     lat2_re;
    logic [W-1:0]     lat2_im;
    logic [AW-1:0]    gen_addr;
    logic             gen_pair1;
    logic [AW-1:0]    addr_lat;
    logic             pair1_lat;
    logic             wr_pend;
    logic [W-1:0]     rd_word [BANKS];
    logic [W-1:0]     rd_q;

    // apb decode
    wire setup   = psel && !penable;
    wire wr_acc  = psel && penable && pwrite && pready;
    wire hit_ctrl   = (paddr == OFS_CTRL);
    wire hit_settle = (paddr == OFS_SETTLE);
    wire hit_pre    = (paddr == OFS_PRE);
    wire hit_post   = (paddr == OFS_POST);
    wire hit_block  = (paddr == OFS_BLOCK);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_addr   = (paddr == OFS_ADDR);
    wire hit_diag   = (paddr == OFS_DIAG);
    wire hit_live   = (paddr == OFS_LIVE);
    wire hit_rdsel  = (paddr == OFS_RDSEL);
    wire hit_rddata = (paddr == OFS_RDDATA);
    wire mapped = hit_ctrl | hit_settle | hit_pre | hit_post | hit_block | hit_status
                | hit_addr | hit_diag | hit_live | hit_rdsel | hit_rddata;

    wire two_ch  = ctrl[CTRL_TWO_CH];
    wire ch2_sel = ctrl[CTRL_CH_SEL];
    wire diag    = ctrl[CTRL_DIAG];
    // start outside idle is refused, so a running capture keeps its address
    wire start   = wr_acc && hit_ctrl && pwdata[CTRL_START] && (state == DCSCR_IDLE);
    wire done_clr = wr_acc && hit_status && pwdata[STAT_DONE];

    wire [W-1:0] diag_re = diag_word[W-1:0];
    wire [W-1:0] diag_im = diag_word[2*W-1:W];

    wire          use_ch2  = two_ch || ch2_sel;
    wire [W-1:0]  sel2_re  = use_ch2 ? ch2_re : ch1_re_i;
    wire [W-1:0]  sel2_im  = use_ch2 ? ch2_im : ch1_im_i;

    // trigger counters
    logic cnt1_load;
    logic cnt2_load;
    logic [CNT_W-1:0] cnt1_val;
    logic [CNT_W-1:0] cnt2_val;
    logic cnt1_dec;
    logic cnt2_dec;
    logic cnt1_zero;
    logic cnt2_zero;

    // in pre and block, the cycle the counter rests at zero is past its window, so it stores nothing
    wire storing = ((state == DCSCR_PRE) && !cnt1_zero)
                || (state == DCSCR_ARMED)
                || ((state == DCSCR_BLOCK) && !cnt2_zero);
    wire take = storing && sample_valid;

    always_comb
    begin
        next_state = state;
        cnt1_load  = 1'b0;
        cnt2_load  = 1'b0;
        cnt1_val   = settle_len;
        cnt2_val   = post_len;
        cnt1_dec   = 1'b0;
        cnt2_dec   = 1'b0;
        case (state)
            DCSCR_IDLE:
            begin
                if (start)
                begin
                    cnt1_load  = 1'b1;
                    next_state = DCSCR_SETTLE;
                end
            end
            DCSCR_SETTLE:
            begin
                cnt1_dec = 1'b1;
                if (cnt1_zero)
                begin
                    cnt1_load  = 1'b1;
                    cnt1_val   = pre_len;
                    next_state = DCSCR_PRE;
                end
            end
            DCSCR_PRE:
            begin
                cnt1_dec = sample_valid;
                if (cnt1_zero)
                    next_state = DCSCR_ARMED;
            end
            DCSCR_ARMED:
            begin
                if (trigger)
                begin
                    cnt2_load  = 1'b1;
                    next_state = DCSCR_POST;
                end
            end
            DCSCR_POST:
            begin
                cnt2_dec = sample_valid;
                if (cnt2_zero)
                begin
                    cnt2_load  = 1'b1;
                    cnt2_val   = block_len;
                    next_state = DCSCR_BLOCK;
                end
            end
            DCSCR_BLOCK:
            begin
                cnt2_dec = sample_valid;
                if (cnt2_zero)
                    next_state = DCSCR_DONE;
            end
            DCSCR_DONE:
                next_state = DCSCR_IDLE;
            default:
                next_state = DCSCR_IDLE;
        endcase
    end

    dcscr_trig_cnt #(.W(CNT_W)) u_cnt1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (cnt1_load),
        .load_val (cnt1_val),
        .dec      (cnt1_dec),
        .expired  (cnt1_zero)
    );

    dcscr_trig_cnt #(.W(CNT_W)) u_cnt2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (cnt2_load),
        .load_val (cnt2_val),
        .dec      (cnt2_dec),
        .expired  (cnt2_zero)
    );

    // pair hand-over: ch2-only never leaves pair 2
    wire addr_wrap     = (gen_addr == ADDR_LAST);
    wire next_pair1    = (!two_ch && !ch2_sel && addr_wrap) ? !gen_pair1 : gen_pair1;
    wire [AW-1:0] next_addr = addr_wrap ? '0 : gen_addr + AW'(1);

    wire we_pair1 = wr_pend && (two_ch || (!ch2_sel && pair1_lat));
    wire we_pair2 = wr_pend && (two_ch || !pair1_lat);
    wire [BANKS-1:0]   bank_we = {we_pair2, we_pair2, we_pair1, we_pair1};
    wire [W-1:0]       bank_din [BANKS];
    assign bank_din[0] = lat1_re;
    assign bank_din[1] = lat1_im;
    assign bank_din[2] = lat2_re;
    assign bank_din[3] = lat2_im;

    wire [AW-1:0] rd_addr = rdsel[AW-1:0];
    wire [1:0]    rd_bank = rdsel[RDSEL_BANK_LSB+1:RDSEL_BANK_LSB];

    genvar b;
    generate
        for (b = 0; b < BANKS; b++)
        begin : g_bank
            logic [W-1:0] mem [DEPTH];
            always_ff @(posedge pclk)
            begin
                if (bank_we[b])
                    mem[addr_lat] <= bank_din[b];
                rd_word[b] <= mem[rd_addr];
            end
        end
    endgenerate

    wire [31:0] status_word = {25'h0, state, 2'b00, (state != DCSCR_IDLE), done};
    wire [31:0] live_word   = {ch1_im_i, ch1_re_i};
    // input path readable on system bus
    wire [31:0] rd_mux =
        hit_ctrl   ? {28'h0, ctrl} :
        hit_settle ? {8'h0, settle_len} :
        hit_pre    ? {8'h0, pre_len} :
        hit_post   ? {8'h0, post_len} :
        hit_block  ? {8'h0, block_len} :
        hit_status ? status_word :
        hit_addr   ? {{(31 - AW){1'b0}}, gen_pair1, gen_addr} :
        hit_diag   ? diag_word :
        hit_live   ? live_word :
        hit_rdsel  ? rdsel :
        hit_rddata ? {16'h0, rd_q} : 32'h0;

    // one wait-free access phase; data captured at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
            pslverr <= setup && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl       <= 4'h0;
            settle_len <= SETTLE_RST;
            pre_len    <= PRE_RST;
            post_len   <= POST_RST;
            block_len  <= BLOCK_RST;
            diag_word  <= 32'h0;
            rdsel      <= 32'h0;
        end
        else if (wr_acc)
        begin
            // start is a pulse, never stored
            if (hit_ctrl)
                ctrl <= {1'b0, pwdata[2:0]};
            if (hit_settle)
                settle_len <= pwdata[CNT_W-1:0];
            if (hit_pre)
                pre_len <= pwdata[CNT_W-1:0];
            if (hit_post)
                post_len <= pwdata[CNT_W-1:0];
            if (hit_block)
                block_len <= pwdata[CNT_W-1:0];
            if (hit_diag)
                diag_word <= pwdata;
            if (hit_rdsel)
                rdsel <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done <= 1'b0;
        else if (state == DCSCR_DONE)
            done <= 1'b1;
        else if (done_clr || start)
            done <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= DCSCR_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat1_re <= '0;
            lat1_im <= '0;
            lat2_re <= '0;
            lat2_im <= '0;
        end
        else if (take)
        begin
            lat1_re <= ch1_re_i;
            lat1_im <= ch1_im_i;
            lat2_re <= sel2_re;
            lat2_im <= sel2_im;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_addr  <= '0;
            gen_pair1 <= 1'b0;
            addr_lat  <= '0;
            pair1_lat <= 1'b0;
            wr_pend   <= 1'b0;
        end
        else
        begin
            wr_pend <= take;
            if (start)
            begin
                gen_addr  <= '0;
                gen_pair1 <= 1'b0;
            end
            else if (take)
            begin
                addr_lat  <= gen_addr;
                pair1_lat <= gen_pair1;
                gen_addr  <= next_addr;
                gen_pair1 <= next_pair1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q        <= '0;
            ch1_re_o    <= '0;
            ch1_im_o    <= '0;
            ch1_re_oe_n <= 1'b1;
            ch1_im_oe_n <= 1'b1;
        end
        else
        begin
            rd_q        <= rd_word[rd_bank];
            ch1_re_o    <= diag_re;
            ch1_im_o    <= diag_im;
            ch1_re_oe_n <= !diag;
            ch1_im_oe_n <= !diag;
        end
    end
endmodule

// >>> verif/dcscr_filt_model.sv
// Purpose: upstream filter model feeding complex samples
// Assumes: one sample per valid cycle
// Notes: slow mode gives valid every other cycle
`timescale 1ns/1ps
module dcscr_filt_model
(
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // bench control
    input  wire logic   run,
    input  wire logic   slow,
    // sample outputs
    output logic        valid,
    output logic [15:0] re1,
    output logic [15:0] im1,
    output logic [15:0] re2,
    output logic [15:0] im2
);
    logic [15:0] k;
    logic [15:0] cyc;
    assign valid = run && (!slow || cyc[0]);
    // lines move while not valid so a stray store never looks like a sample
    assign re1 = valid ? k : ~cyc;
    assign im1 = valid ? k + 16'h1000 : cyc;
    assign re2 = valid ? k + 16'h2000 : cyc ^ 16'h00ff;
    assign im2 = valid ? k + 16'h3000 : cyc ^ 16'h0f0f;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            k   <= 16'h0;
            cyc <= 16'h0;
        end
        else
        begin
            cyc <= cyc + 16'h1;
            if (valid)
                k <= k + 16'h1;
        end
    end
endmodule

// >>> verif/dcscr_checker.sv
// Purpose: port assertions for the capture ram
// Assumes: one pclk domain
// Notes: bound to dcscr_top below
`timescale 1ns/1ps
module dcscr_checker
    import dcscr_pkg::*;
#(
    parameter int unsigned W = SAMPLE_W
)
(
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // apb
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // two-way lines
    input wire logic [W-1:0] ch1_re_o,
    input wire logic         ch1_re_oe_n,
    input wire logic [W-1:0] ch1_im_o,
    input wire logic         ch1_im_oe_n
);
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pwrite && (paddr == OFS_CTRL);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_live_rd;
        psel && !penable && !pwrite && (paddr == OFS_LIVE) && !ch1_re_oe_n ##1 !ch1_re_oe_n;
    endsequence
    property p_rdy;
        s_setup |=> pready;
    endproperty
    property p_rdy_src;
        pready |-> $past(psel && !penable);
    endproperty
    property p_err_rdy;
        pslverr |-> pready;
    endproperty
    property p_rd_zero;
        !pready |-> prdata == 32'h0;
    endproperty
    property p_unmap;
        psel && !penable && (paddr > OFS_RDDATA) |=> pslverr && prdata == 32'h0;
    endproperty
    property p_oe_pair;
        ch1_re_oe_n == ch1_im_oe_n;
    endproperty
    property p_oe_src;
        $changed(ch1_re_oe_n) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    property p_diag_live;
        s_live_rd |-> prdata == {ch1_im_o, ch1_re_o};
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    a_rdy_src: assert property (p_rdy_src) else $error("ready without setup");
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside access");
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
    a_oe_src: assert property (p_oe_src) else $error("direction changed alone");
    a_diag_live: assert property (p_diag_live) else $error("live lines wrong");
endmodule
bind dcscr_top dcscr_checker #(.W(W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch1_re_o(ch1_re_o), .ch1_re_oe_n(ch1_re_oe_n),
    .ch1_im_o(ch1_im_o), .ch1_im_oe_n(ch1_im_oe_n));

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the capture ram
// Assumes: trigger held high, small settle, pre and post counts
// Notes: one run crosses a full bank pair
`timescale 1ns/1ps
module tb_top
    import dcscr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, addr_q;
    logic [15:0] re_o, im_o, re_w, im_w, m_re, m_im, re2, im2;
    logic [15:0] old0, w0, w1, w2, w3, prev;
    logic        re_oe_n, im_oe_n, valid, trigger, run, slow;
    int          errors, tests_run;
    dcscr_top #(.EXPANDED(1'b0), .W(16)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch1_re_i(re_w),
        .ch1_re_o(re_o), .ch1_re_oe_n(re_oe_n), .ch1_im_i(im_w), .ch1_im_o(im_o),
        .ch1_im_oe_n(im_oe_n), .ch2_re(re2), .ch2_im(im2), .sample_valid(valid),
        .trigger(trigger));
    dcscr_filt_model u_filt (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
        .valid(valid), .re1(m_re), .im1(m_im), .re2(re2), .im2(im2));
    // the design wins the two-way lines while its enable is low
    assign re_w = re_oe_n ? m_re : re_o;
    assign im_w = im_oe_n ? m_im : im_o;
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            check(32'h0, 32'h1);
    endtask
    task automatic bank_rd(input logic [1:0] b, input logic [15:0] a, output logic [15:0] w);
        apb(1'b1, OFS_RDSEL, {b, 14'h0, a});
        repeat (2) @(posedge pclk);
        apb(1'b0, OFS_RDDATA, 32'h0);
        w = q[15:0];
    endtask
    task automatic acquire(input logic [31:0] ctrl, input logic [23:0] blk);
        int n;
        n = 0;
        apb(1'b1, OFS_SETTLE, 32'h2);
        apb(1'b1, OFS_PRE, 32'h1);
        apb(1'b1, OFS_POST, 32'h1);
        apb(1'b1, OFS_BLOCK, {8'h0, blk});
        apb(1'b1, OFS_CTRL, ctrl);
        do
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        while (q[STAT_DONE] !== 1'b1 && n < 40000);
        check(32'(q[STAT_DONE]), 32'h1);
        apb(1'b1, OFS_STATUS, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(32'(q[STAT_DONE]), 32'h0);
        apb(1'b0, OFS_ADDR, 32'h0);
        addr_q = q;
    endtask
    task automatic t_reset();
        apb(1'b0, OFS_SETTLE, 32'h0);
        check(q, {8'h0, SETTLE_RST});
        apb(1'b0, OFS_BLOCK, 32'h0);
        check(q, {8'h0, BLOCK_RST});
        apb(1'b0, 8'h40, 32'h0);
        check({last_err, q[30:0]}, 32'h80000000);
    endtask
    task automatic t_diag();
        apb(1'b1, OFS_DIAG, 32'h5a5aa5a5);
        apb(1'b1, OFS_CTRL, 32'h4);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check({im_o, re_o}, 32'h5a5aa5a5);
        check({30'h0, re_oe_n, im_oe_n}, 32'h0);
        apb(1'b0, OFS_LIVE, 32'h0);
        check(q, 32'h5a5aa5a5);
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check({30'h0, re_oe_n, im_oe_n}, 32'h3);
    endtask
    task automatic t_two();
        acquire(32'h9, 24'h4);
        check(32'(addr_q[15:0] inside {16'h5, 16'h6}), 32'h1);
        for (int a = 0; a < int'(addr_q[15:0]); a++)
        begin
            bank_rd(2'd0, 16'(a), w0);
            bank_rd(2'd1, 16'(a), w1);
            bank_rd(2'd2, 16'(a), w2);
            bank_rd(2'd3, 16'(a), w3);
            check({16'h0, w1 - w0}, 32'h1000);
            check({16'h0, w2 - w0}, 32'h2000);
            check({16'h0, w3 - w0}, 32'h3000);
            if (a > 0)
                check(32'((w0 - prev) inside {16'h1, 16'h2, 16'h3}), 32'h1);
            prev = w0;
        end
    endtask
    task automatic t_ch2();
        bank_rd(2'd0, 16'h0, old0);
        acquire(32'ha, 24'h4);
        check(32'(addr_q[16]), 32'h0);
        bank_rd(2'd0, 16'h0, w0);
        check({16'h0, w0}, {16'h0, old0});
        bank_rd(2'd2, 16'h0, w2);
        bank_rd(2'd3, 16'h0, w3);
        check({28'h0, w2[15:12]}, 32'h2);
        check({16'h0, w3 - w2}, 32'h1000);
    endtask
    task automatic t_long();
        slow <= 1'b0;
        acquire(32'h8, 24'h10000);
        check(32'(addr_q[16:0] inside {17'h10001, 17'h10002}), 32'h1);
        bank_rd(2'd2, 16'h0, w2);
        check({28'h0, w2[15:12]}, 32'h0);
        bank_rd(2'd0, 16'h0, w0);
        bank_rd(2'd1, 16'h0, w1);
        check(32'(w0 !== old0), 32'h1);
        check({16'h0, w1 - w0}, 32'h1000);
    endtask
    initial
    begin
        errors = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        run = 1'b0;
        slow = 1'b1;
        trigger = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        run <= 1'b1;
        trigger <= 1'b1;
        t_reset();
        t_diag();
        t_two();
        t_ch2();
        t_long();
        print_verdict();
    end
    initial
    begin
        repeat (100000) @(posedge pclk);
        errors++;
        print_verdict();
    end
endmodule
